// >>> design/rtcc_pkg.sv
// package: register map, field layout and timing of the calendar clock
//
// Behaviour
// - reset clears only bank select, seconds_a, irq enable and reset-register fields.
// - time, calendar and alarm values keep their contents across reset.
// - clock bank reads return live counter values.
// - alarm bank reads return current alarm, hour mode and leap phase.
// - clock bank holds BCD minutes, hours, weekday, date, month, year.
// - alarm bank holds alarm fields, hour mode bit 0, leap phase bits 1..0.
// - seconds exist only in clock bank; alarm bank seconds reads zero.
// - seconds read bit 7 zero, BCD 00 to 59 in bits 6..0.
// - reset register: 1 Hz enable, 16 Hz enable, clock reset, alarm reset.
// - one bank select bit steers shared addresses to clock or alarm bank.
// - every year with leap phase zero is a leap year, no century rule.
// - unused addresses read zero and ignore writes.
// - hour mode 1 counts 00..23, 0 counts 12-hour with PM in bit 5.
package rtcc_pkg;

    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_SEC = 4'h0;
    localparam logic [3:0] IDX_MIN = 4'h1;
    localparam logic [3:0] IDX_HOUR = 4'h2;
    localparam logic [3:0] IDX_WDAY = 4'h4;
    localparam logic [3:0] IDX_DATE = 4'h5;
    localparam logic [3:0] IDX_MONTH = 4'h6;
    localparam logic [3:0] IDX_YEAR = 4'h7;
    localparam logic [3:0] IDX_BANK = 4'h8;
    localparam logic [3:0] IDX_RST = 4'hC;

    // bank control fields
    localparam int BIT_PAGE = 0;
    localparam int BIT_ALM_EN = 2;
    localparam int BIT_CLK_EN = 3;
    localparam int BIT_SECONDS_A = 4;
    localparam int BIT_INT_EN = 7;

    // reset control fields
    localparam int BIT_ALM_RST = 4;
    localparam int BIT_CNT_RST = 5;
    localparam int BIT_EN16 = 6;
    localparam int BIT_EN1 = 7;

    // values after reset
    localparam logic RST_PAGE = 1'b0;
    localparam logic RST_SECONDS_A = 1'b0;
    localparam logic RST_INT_EN = 1'b0;
    localparam logic RST_EN16 = 1'b0;
    localparam logic RST_EN1 = 1'b0;

    // BCD limits
    localparam logic [6:0] SEC_MAX = 7'h59;
    localparam logic [6:0] MIN_MAX = 7'h59;
    localparam logic [5:0] HOUR24_MAX = 6'h23;
    localparam logic [4:0] HOUR12_MAX = 5'h11;
    localparam logic [2:0] WDAY_MAX = 3'h6;
    localparam logic [4:0] MONTH_MAX = 5'h12;
    localparam logic [7:0] YEAR_MAX = 8'h99;
    localparam logic [6:0] SEC_HALF = 7'h30;

    // timing: one 16 Hz step, sixteen of them make a second
    localparam longint CLK_PERIOD_NS = 50;
    localparam longint HZ16_PERIOD_NS = 62_500_000;
    localparam int HZ16_CYCLES = int'(HZ16_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [3:0] SUB16_LAST = 4'hF;

    // register write request from the bus front end
    typedef struct packed {
        logic wr;
        logic [3:0] idx;
        logic [7:0] wdata;
    } rtcc_wr_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WR = 2'b01,
        BUS_RD = 2'b10,
        BUS_RDY = 2'b11
    } rtcc_bus_st_t;

endpackage

// >>> design/rtcc_bcd_ctr.sv
// one BCD counter column of the calendar
`timescale 1ns/1ps
module rtcc_bcd_ctr #(
    parameter int W = 8
) (
    // clock
    input wire logic hclk,
    input wire logic clk_en,
    // control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic inc,
    input wire logic [W-1:0] min_val,
    input wire logic [W-1:0] max_val,
    // state
    output logic [W-1:0] val,
    output logic wrap
);
    logic [W-1:0] val_q;
    logic [7:0] v8;
    logic [7:0] inc8;

    assign v8 = 8'(val_q);
    assign inc8 = (v8[3:0] == 4'h9) ? {v8[7:4] + 4'h1, 4'h0} : v8 + 8'h01;
    assign wrap = inc & (val_q == max_val);
    assign val = val_q;

    // no reset on purpose: time survives a system reset
    always_ff @(posedge hclk) begin
        if (clk_en) begin
            if (load) begin
                val_q <= load_val;
            end else if (wrap) begin
                val_q <= min_val;
            end else if (inc) begin
                val_q <= inc8[W-1:0];
            end
        end
    end
endmodule

// >>> design/rtcc_ahb_slv.sv
// AHB-Lite slave front end for the calendar registers
`timescale 1ns/1ps
module rtcc_ahb_slv (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register side
    output rtcc_pkg::rtcc_wr_t wreq,
    output logic [3:0] rd_idx,
    input wire logic [7:0] rd_data
);
    rtcc_pkg::rtcc_bus_st_t st_q;
    logic [3:0] idx_q;
    logic [31:0] hrdata_q;
    logic accept;

    // only whole-word transfers exist, so size is not decoded
    assign accept = hsel & htrans[1] & hready;
    assign hreadyout = clk_en & (st_q != rtcc_pkg::BUS_RD);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign rd_idx = idx_q;
    assign wreq.wr = (st_q == rtcc_pkg::BUS_WR);
    assign wreq.idx = idx_q;
    assign wreq.wdata = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= rtcc_pkg::BUS_IDLE;
            idx_q <= 4'h0;
        end else if (clk_en) begin
            case (st_q)
                rtcc_pkg::BUS_RD: begin
                    st_q <= rtcc_pkg::BUS_RDY;
                end
                rtcc_pkg::BUS_IDLE, rtcc_pkg::BUS_WR, rtcc_pkg::BUS_RDY: begin
                    if (accept) begin
                        st_q <= hwrite ? rtcc_pkg::BUS_WR : rtcc_pkg::BUS_RD;
                        idx_q <= haddr[5:2];
                    end else begin
                        st_q <= rtcc_pkg::BUS_IDLE;
                    end
                end
                default: begin
                    st_q <= rtcc_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // one wait state lets read data come from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (clk_en && st_q == rtcc_pkg::BUS_RD) begin
            hrdata_q <= {24'h00_0000, rd_data};
        end
    end
endmodule

// >>> design/rtcc_core.sv
// calendar clock top: counters, alarm, prescaler and register file
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module rtcc_core #(
    parameter int HZ16_DIV = rtcc_pkg::HZ16_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // events
    output logic alarm_out,
    output logic alarm_irq,
    output logic hz1_out,
    output logic hz16_out
);
    rtcc_pkg::rtcc_wr_t wreq;
    logic [3:0] rd_idx;
    logic [7:0] rd_data;

    // control state
    logic page_q;
    logic seconds_a_q;
    logic int_en_q;
    logic clock_run_q;
    logic alarm_en_q;
    logic en1_q;
    logic en16_q;

    // prescaler
    logic [31:0] pre_q;
    logic [3:0] sub16_q;
    logic tick16;
    logic tick1;
    logic cnt_rst;

    // counters
    logic [6:0] sec_v;
    logic [6:0] min_v;
    logic [5:0] hour_q;
    logic [2:0] wday_v;
    logic [5:0] date_v;
    logic [4:0] month_v;
    logic [7:0] year_v;
    logic [1:0] leap_q;
    logic hour_mode_q;
    logic sec_wrap;
    logic min_wrap;
    logic date_wrap;
    logic month_wrap;
    logic sec_inc;
    logic min_inc;
    logic hour_inc;
    logic day_carry;
    logic adj_go;
    logic adj_carry;
    logic [5:0] dim;
    logic [5:0] hour_nxt;

    // alarm fields
    logic [6:0] alm_min_q;
    logic [5:0] alm_hour_q;
    logic [2:0] alm_wday_q;
    logic [5:0] alm_date_q;
    logic alarm_q;
    logic irq_q;
    logic hz1_q;
    logic hz16_q;

    logic wr_clk;
    logic wr_alm;

    rtcc_ahb_slv u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wreq(wreq),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    assign wr_clk = wreq.wr & ~page_q;
    assign wr_alm = wreq.wr & page_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            page_q <= rtcc_pkg::RST_PAGE;
            seconds_a_q <= rtcc_pkg::RST_SECONDS_A;
            int_en_q <= rtcc_pkg::RST_INT_EN;
        end else if (clk_en) begin
            if (wreq.wr && wreq.idx == rtcc_pkg::IDX_BANK) begin
                page_q <= wreq.wdata[rtcc_pkg::BIT_PAGE];
                seconds_a_q <= wreq.wdata[rtcc_pkg::BIT_SECONDS_A];
                int_en_q <= wreq.wdata[rtcc_pkg::BIT_INT_EN];
            end else if (adj_go) begin
                seconds_a_q <= 1'b0;
            end
        end
    end

    // run and alarm enables keep state across reset
    always_ff @(posedge hclk) begin
        if (clk_en && wreq.wr && wreq.idx == rtcc_pkg::IDX_BANK) begin
            clock_run_q <= wreq.wdata[rtcc_pkg::BIT_CLK_EN];
            alarm_en_q <= wreq.wdata[rtcc_pkg::BIT_ALM_EN];
        end
    end

    // reset register enables, clock and alarm reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en1_q <= rtcc_pkg::RST_EN1;
            en16_q <= rtcc_pkg::RST_EN16;
        end else if (clk_en && wreq.wr && wreq.idx == rtcc_pkg::IDX_RST) begin
            en1_q <= wreq.wdata[rtcc_pkg::BIT_EN1];
            en16_q <= wreq.wdata[rtcc_pkg::BIT_EN16];
        end
    end

    assign cnt_rst = wreq.wr & (wreq.idx == rtcc_pkg::IDX_RST)
        & wreq.wdata[rtcc_pkg::BIT_CNT_RST];

    // prescaler; clock reset restarts the second
    assign tick16 = (pre_q == 32'(HZ16_DIV - 1));
    assign tick1 = tick16 & (sub16_q == rtcc_pkg::SUB16_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 32'h0000_0000;
            sub16_q <= 4'h0;
        end else if (clk_en) begin
            if (cnt_rst) begin
                pre_q <= 32'h0000_0000;
                sub16_q <= 4'h0;
            end else if (tick16) begin
                pre_q <= 32'h0000_0000;
                sub16_q <= sub16_q + 4'h1;
            end else begin
                pre_q <= pre_q + 32'h0000_0001;
            end
        end
    end

    // seconds seconds_a: round to the nearest minute
    assign adj_go = seconds_a_q;
    assign adj_carry = adj_go & (sec_v >= rtcc_pkg::SEC_HALF);
    assign sec_inc = tick1 & clock_run_q & ~adj_go;

    rtcc_bcd_ctr #(.W(7)) u_sec (
        .hclk(hclk),
        .clk_en(clk_en),
        .load((wr_clk && wreq.idx == rtcc_pkg::IDX_SEC) || adj_go),
        .load_val(adj_go ? 7'h00 : wreq.wdata[6:0]),
        .inc(sec_inc),
        .min_val(7'h00),
        .max_val(rtcc_pkg::SEC_MAX),
        .val(sec_v),
        .wrap(sec_wrap)
    );

    assign min_inc = sec_wrap | adj_carry;

    rtcc_bcd_ctr #(.W(7)) u_min (
        .hclk(hclk),
        .clk_en(clk_en),
        .load(wr_clk && wreq.idx == rtcc_pkg::IDX_MIN),
        .load_val(wreq.wdata[6:0]),
        .inc(min_inc),
        .min_val(7'h00),
        .max_val(rtcc_pkg::MIN_MAX),
        .val(min_v),
        .wrap(min_wrap)
    );

    assign hour_inc = min_wrap;
    assign day_carry = hour_inc & (hour_mode_q ?
        (hour_q == rtcc_pkg::HOUR24_MAX) :
        (hour_q == {1'b1, rtcc_pkg::HOUR12_MAX}));

    always_comb begin
        if (hour_mode_q) begin
            if (hour_q == rtcc_pkg::HOUR24_MAX) begin
                hour_nxt = 6'h00;
            end else if (hour_q[3:0] == 4'h9) begin
                hour_nxt = {hour_q[5:4] + 2'h1, 4'h0};
            end else begin
                hour_nxt = hour_q + 6'h01;
            end
        end else begin
            if (hour_q[4:0] == rtcc_pkg::HOUR12_MAX) begin
                hour_nxt = {~hour_q[5], 5'h00};
            end else if (hour_q[3:0] == 4'h9) begin
                hour_nxt = {hour_q[5], 5'h10};
            end else begin
                hour_nxt = {hour_q[5], hour_q[4:0] + 5'h01};
            end
        end
    end

    always_ff @(posedge hclk) begin
        if (clk_en) begin
            if (wr_clk && wreq.idx == rtcc_pkg::IDX_HOUR) begin
                hour_q <= wreq.wdata[5:0];
            end else if (hour_inc) begin
                hour_q <= hour_nxt;
            end
        end
    end

    rtcc_bcd_ctr #(.W(3)) u_wday (
        .hclk(hclk),
        .clk_en(clk_en),
        .load(wr_clk && wreq.idx == rtcc_pkg::IDX_WDAY),
        .load_val(wreq.wdata[2:0]),
        .inc(day_carry),
        .min_val(3'h0),
        .max_val(rtcc_pkg::WDAY_MAX),
        .val(wday_v),
        .wrap()
    );

    // february length from leap phase only
    always_comb begin
        case (month_v)
            5'h02: dim = (leap_q == 2'h0) ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: dim = 6'h30;
            default: dim = 6'h31;
        endcase
    end

    rtcc_bcd_ctr #(.W(6)) u_date (
        .hclk(hclk),
        .clk_en(clk_en),
        .load(wr_clk && wreq.idx == rtcc_pkg::IDX_DATE),
        .load_val(wreq.wdata[5:0]),
        .inc(day_carry),
        .min_val(6'h01),
        .max_val(dim),
        .val(date_v),
        .wrap(date_wrap)
    );

    rtcc_bcd_ctr #(.W(5)) u_month (
        .hclk(hclk),
        .clk_en(clk_en),
        .load(wr_clk && wreq.idx == rtcc_pkg::IDX_MONTH),
        .load_val(wreq.wdata[4:0]),
        .inc(date_wrap),
        .min_val(5'h01),
        .max_val(rtcc_pkg::MONTH_MAX),
        .val(month_v),
        .wrap(month_wrap)
    );

    rtcc_bcd_ctr #(.W(8)) u_year (
        .hclk(hclk),
        .clk_en(clk_en),
        .load(wr_clk && wreq.idx == rtcc_pkg::IDX_YEAR),
        .load_val(wreq.wdata),
        .inc(month_wrap),
        .min_val(8'h00),
        .max_val(rtcc_pkg::YEAR_MAX),
        .val(year_v),
        .wrap()
    );

    // alarm bank fields and hour mode
    always_ff @(posedge hclk) begin
        if (clk_en && wr_alm) begin
            case (wreq.idx)
                rtcc_pkg::IDX_MIN: alm_min_q <= wreq.wdata[6:0];
                rtcc_pkg::IDX_HOUR: alm_hour_q <= wreq.wdata[5:0];
                rtcc_pkg::IDX_WDAY: alm_wday_q <= wreq.wdata[2:0];
                rtcc_pkg::IDX_DATE: alm_date_q <= wreq.wdata[5:0];
                rtcc_pkg::IDX_MONTH: hour_mode_q <= wreq.wdata[0];
                default: begin
                end
            endcase
        end
    end

    // leap phase steps at each new year
    always_ff @(posedge hclk) begin
        if (clk_en) begin
            if (wr_alm && wreq.idx == rtcc_pkg::IDX_YEAR) begin
                leap_q <= wreq.wdata[1:0];
            end else if (month_wrap) begin
                leap_q <= leap_q + 2'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            if (wreq.wr && wreq.idx == rtcc_pkg::IDX_RST
                && wreq.wdata[rtcc_pkg::BIT_ALM_RST]) begin
                alarm_q <= 1'b0;
                irq_q <= 1'b0;
            end else begin
                alarm_q <= alarm_en_q && min_v == alm_min_q
                    && hour_q == alm_hour_q && wday_v == alm_wday_q
                    && date_v == alm_date_q;
                irq_q <= int_en_q && alarm_en_q && min_v == alm_min_q
                    && hour_q == alm_hour_q && wday_v == alm_wday_q
                    && date_v == alm_date_q;
            end
        end
    end

    // gated 1 Hz and 16 Hz pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hz1_q <= 1'b0;
            hz16_q <= 1'b0;
        end else if (clk_en) begin
            hz1_q <= tick1 & en1_q;
            hz16_q <= tick16 & en16_q;
        end
    end

    assign alarm_out = alarm_q;
    assign alarm_irq = irq_q;
    assign hz1_out = hz1_q;
    assign hz16_out = hz16_q;

    always_comb begin
        rd_data = 8'h00;
        case (rd_idx)
            rtcc_pkg::IDX_SEC: rd_data = page_q ? 8'h00 : {1'b0, sec_v};
            rtcc_pkg::IDX_MIN:
                rd_data = {1'b0, page_q ? alm_min_q : min_v};
            rtcc_pkg::IDX_HOUR:
                rd_data = {2'b00, page_q ? alm_hour_q : hour_q};
            rtcc_pkg::IDX_WDAY:
                rd_data = {5'h00, page_q ? alm_wday_q : wday_v};
            rtcc_pkg::IDX_DATE:
                rd_data = {2'b00, page_q ? alm_date_q : date_v};
            rtcc_pkg::IDX_MONTH:
                rd_data = page_q ? {7'h00, hour_mode_q} : {3'h0, month_v};
            rtcc_pkg::IDX_YEAR:
                rd_data = page_q ? {6'h00, leap_q} : year_v;
            rtcc_pkg::IDX_BANK:
                rd_data = {int_en_q, 2'b00, seconds_a_q, clock_run_q,
                    alarm_en_q, 1'b0, page_q};
            rtcc_pkg::IDX_RST: rd_data = {en1_q, en16_q, 6'h00};
            default: rd_data = 8'h00;
        endcase
    end
endmodule

// >>> bench/rtcc_core_sva.sv
// checker: bus, event and reset assertions for the calendar clock
`timescale 1ns/1ps
module rtcc_core_sva #(
    parameter int HZ16_DIV = 4
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // events
    input wire logic alarm_out,
    input wire logic alarm_irq,
    input wire logic hz1_out,
    input wire logic hz16_out
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic acc = hsel & htrans[1] & hready & clk_en;
    int cnt_q;
    logic seen_q;
    sequence rd_go;
        acc && !hwrite;
    endsequence
    sequence rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    function automatic logic [7:0] zmask(logic [3:0] i);
        case (i)
            4'h0, 4'h1: zmask = 8'h80;
            4'h2, 4'h5: zmask = 8'hC0;
            4'h4: zmask = 8'hF8;
            4'h6: zmask = 8'hE0;
            4'h7, 4'h8: zmask = 8'h00;
            4'hC: zmask = 8'h3F;
            default: zmask = 8'hFF;
        endcase
    endfunction
    // spacing is only judged after a pulse with no prescaler restart between
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 0;
            seen_q <= 1'b0;
        end else if (hz16_out) begin
            cnt_q <= 0;
            seen_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1;
            if (acc && hwrite && haddr[5:2] == 4'hC) begin
                seen_q <= 1'b0;
            end
        end
    end
    a_read_wait: assert property (rd_go |=> rd_wait)
        else $error("read wait state wrong");
    a_write_nowait: assert property (acc && hwrite |=> hreadyout)
        else $error("write stalled");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unused_bits: assert property (rd_go |-> ##2
        ((hrdata[7:0] & zmask($past(haddr[5:2], 2))) == 8'h00))
        else $error("unused read bits set");
    a_rdata_holds: assert property ($changed(hrdata) |->
        $past(hreadyout) == 1'b0)
        else $error("read data moved");
    a_irq_has_out: assert property (alarm_irq |-> alarm_out)
        else $error("irq without alarm");
    a_quiet_reset: assert property ($rose(hresetn) |->
        (!hz1_out && !hz16_out && !alarm_irq) [*3])
        else $error("event after reset");
    a_hz16_space: assert property (hz16_out && seen_q |->
        cnt_q == HZ16_DIV - 1)
        else $error("16 Hz spacing wrong");
    a_hz1_single: assert property (hz1_out |=> !hz1_out [*8])
        else $error("1 Hz pulse too long");
endmodule
bind rtcc_core rtcc_core_sva #(.HZ16_DIV(HZ16_DIV)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .alarm_out(alarm_out), .alarm_irq(alarm_irq), .hz1_out(hz1_out),
    .hz16_out(hz16_out)
);

// >>> bench/rtcc_core_tb_top.sv
// testbench: register, calendar and alarm checks for the calendar clock
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module rtcc_core_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire logic hreadyout, hresp, alarm_out, alarm_irq, hz1_out, hz16_out;
    wire logic [31:0] hrdata;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [7:0] q;
    logic [3:0] ix [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
    logic [7:0] v0 [7] = '{8'h45, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99};
    logic [7:0] v1 [7] = '{8'h00, 8'h15, 8'h07, 8'h03, 8'h10, 8'h01, 8'h02};
    logic [3:0] un [7] = '{4'h3, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF};

    // short prescaler: one second is 64 clocks
    rtcc_core #(.HZ16_DIV(4)) dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .alarm_out(alarm_out),
        .alarm_irq(alarm_irq), .hz1_out(hz1_out), .hz16_out(hz16_out)
    );

    initial begin
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // ready and read data both taken at the rising edge that ends a phase
    task wait_rdy;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata[7:0];
    endtask
    task xfer(input logic w, input logic [3:0] i, input logic [7:0] d);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= {26'h0, i, 2'b00};
        htrans <= 2'h2;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy;
    endtask
    task wr(input logic [3:0] i, input logic [7:0] d);
        xfer(1'b1, i, d);
    endtask
    task chk_rd(input logic [3:0] i, input logic [7:0] e);
        xfer(1'b0, i, 8'h00);
        `CHK(q, e)
    endtask

    task t_reset;
        xfer(1'b0, rtcc_pkg::IDX_BANK, 8'h00);
        `CHK(q & 8'h91, 8'h00)
        chk_rd(rtcc_pkg::IDX_RST, 8'h00);
        $display("test reset done");
    endtask
    task t_banks;
        wr(rtcc_pkg::IDX_BANK, 8'h00);
        for (int k = 0; k < 7; k++) wr(ix[k], v0[k]);
        wr(rtcc_pkg::IDX_BANK, 8'h01);
        for (int k = 1; k < 7; k++) wr(ix[k], v1[k]);
        for (int k = 0; k < 7; k++) chk_rd(ix[k], v1[k]);
        wr(rtcc_pkg::IDX_BANK, 8'h00);
        for (int k = 0; k < 7; k++) chk_rd(ix[k], v0[k]);
        $display("test banks done");
    endtask
    task t_unmapped;
        for (int k = 0; k < 7; k++) begin
            wr(un[k], 8'hFF);
            chk_rd(un[k], 8'h00);
        end
        chk_rd(rtcc_pkg::IDX_MIN, 8'h59);
        $display("test unmapped done");
    endtask
    task t_keep;
        hresetn <= 1'b0;
        idle(2);
        hresetn <= 1'b1;
        idle(1);
        chk_rd(rtcc_pkg::IDX_MIN, 8'h59);
        chk_rd(rtcc_pkg::IDX_DATE, 8'h31);
        chk_rd(rtcc_pkg::IDX_YEAR, 8'h99);
        $display("test keep done");
    endtask
    task t_roll(input logic m, input logic [7:0] hi, he, di, mi, wde, de, me);
        int n;
        wr(rtcc_pkg::IDX_BANK, 8'h01);
        wr(rtcc_pkg::IDX_MONTH, {7'h0, m});
        wr(rtcc_pkg::IDX_YEAR, 8'h00);
        // whole time loaded before the clock runs
        wr(rtcc_pkg::IDX_BANK, 8'h00);
        wr(rtcc_pkg::IDX_SEC, 8'h59);
        wr(rtcc_pkg::IDX_MIN, 8'h59);
        wr(rtcc_pkg::IDX_HOUR, hi);
        wr(rtcc_pkg::IDX_WDAY, 8'h06);
        wr(rtcc_pkg::IDX_DATE, di);
        wr(rtcc_pkg::IDX_MONTH, mi);
        wr(rtcc_pkg::IDX_YEAR, 8'h24);
        // low bits always written as ones
        wr(rtcc_pkg::IDX_RST, 8'h27);
        wr(rtcc_pkg::IDX_RST, 8'hC7);
        wr(rtcc_pkg::IDX_BANK, 8'h08);
        n = 0;
        @(negedge hclk);
        while (hz1_out !== 1'b1 && n < 300) begin
            @(negedge hclk);
            n++;
        end
        @(posedge hclk);
        `CHK(n < 300, 1'b1)
        wr(rtcc_pkg::IDX_BANK, 8'h00);
        chk_rd(rtcc_pkg::IDX_SEC, 8'h00);
        chk_rd(rtcc_pkg::IDX_SEC, 8'h00);
        chk_rd(rtcc_pkg::IDX_MIN, 8'h00);
        chk_rd(rtcc_pkg::IDX_HOUR, he);
        chk_rd(rtcc_pkg::IDX_WDAY, wde);
        chk_rd(rtcc_pkg::IDX_DATE, de);
        chk_rd(rtcc_pkg::IDX_MONTH, me);
        chk_rd(rtcc_pkg::IDX_YEAR, (mi == 8'h12) ? 8'h25 : 8'h24);
        // leap phase steps once per new year
        wr(rtcc_pkg::IDX_BANK, 8'h01);
        chk_rd(rtcc_pkg::IDX_YEAR, {7'h0, mi == 8'h12});
        wr(rtcc_pkg::IDX_RST, 8'h07);
        $display("test rollover done");
    endtask
    task t_alarm;
        wr(rtcc_pkg::IDX_BANK, 8'h01);
        wr(rtcc_pkg::IDX_MIN, 8'h00);
        wr(rtcc_pkg::IDX_HOUR, 8'h20);
        wr(rtcc_pkg::IDX_WDAY, 8'h06);
        wr(rtcc_pkg::IDX_DATE, 8'h05);
        wr(rtcc_pkg::IDX_BANK, 8'h84);
        idle(2);
        `CHK(alarm_out, 1'b1)
        `CHK(alarm_irq, 1'b1)
        wr(rtcc_pkg::IDX_BANK, 8'h04);
        idle(2);
        `CHK(alarm_irq, 1'b0)
        `CHK(alarm_out, 1'b1)
        wr(rtcc_pkg::IDX_BANK, 8'h05);
        wr(rtcc_pkg::IDX_MIN, 8'h01);
        idle(2);
        `CHK(alarm_out, 1'b0)
        // seconds_a rounds 31 s up to the next minute
        wr(rtcc_pkg::IDX_BANK, 8'h00);
        wr(rtcc_pkg::IDX_SEC, 8'h31);
        wr(rtcc_pkg::IDX_BANK, 8'h10);
        chk_rd(rtcc_pkg::IDX_SEC, 8'h00);
        chk_rd(rtcc_pkg::IDX_MIN, 8'h01);
        $display("test alarm done");
    endtask

    initial begin
        idle(2);
        hresetn <= 1'b1;
        idle(1);
        t_reset;
        t_banks;
        t_unmapped;
        t_keep;
        t_roll(1'b1, 8'h23, 8'h00, 8'h28, 8'h02, 8'h00, 8'h29, 8'h02);
        t_roll(1'b1, 8'h23, 8'h00, 8'h31, 8'h12, 8'h00, 8'h01, 8'h01);
        t_roll(1'b0, 8'h31, 8'h00, 8'h29, 8'h02, 8'h00, 8'h01, 8'h03);
        t_roll(1'b0, 8'h11, 8'h20, 8'h05, 8'h03, 8'h06, 8'h05, 8'h03);
        t_alarm;
        report_and_stop();
    end
endmodule
